// ---- rtl/pio_regs.svh ----
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define PIO_DW              32
`define PIO_AW              7

// ----------------------------------------
// Clock and bus timing
// ----------------------------------------
`define PIO_CLK_NS          25
`define PIO_TCSL_NS         32
`define PIO_TCSH_NS         13
`define PIO_TCYCLE_NS       45
`define PIO_TACYC_NS        45
`define PIO_TADV_NS         40
`define PIO_TRAW_NS         315
`define PIO_TRAR_NS         135
`define PIO_TCSL_CYC        ((`PIO_TCSL_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_TCSH_CYC        ((`PIO_TCSH_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_TCYCLE_CYC      ((`PIO_TCYCLE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_TACYC_CYC       ((`PIO_TACYC_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_TADV_CYC        (((`PIO_TADV_NS / `PIO_CLK_NS) < 1) ? 1 : (`PIO_TADV_NS / `PIO_CLK_NS))
`define PIO_TRAW_CYC        ((`PIO_TRAW_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_TRAR_CYC        ((`PIO_TRAR_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
// Host read hold: address cycle plus one edge of round trip through the device
`define PIO_RD_HOLD_CYC     (`PIO_TACYC_CYC + `PIO_TADV_CYC)

// ----------------------------------------
// Burst limits
// ----------------------------------------
`define PIO_BURST32_MAX     8
`define PIO_BURST16_MAX     16

// ----------------------------------------
// Address map, halfword address A[7:1]
// ----------------------------------------
`define PIO_RXD_TOP         3'h0
`define PIO_RXS_ADDR        7'h20
`define PIO_TXS_ADDR        7'h24
`define PIO_RXINFO_ADDR     7'h3e

`endif

// ---- rtl/pio_pkg.sv ----
package pio_pkg;
	`include "pio_regs.svh"

	// ----------------------------------------
	// Types
	// ----------------------------------------
	// Read target, Gray coded
	typedef enum logic [1:0] {
		PIO_TGT_CSR = 2'h0,
		PIO_TGT_RXD = 2'h1,
		PIO_TGT_RXS = 2'h3,
		PIO_TGT_TXS = 2'h2
	} pio_tgt_e;

	// Host cycle state, Gray along idle, active, off
	typedef enum logic [1:0] {
		PIO_ST_IDLE = 2'h0,
		PIO_ST_ACT  = 2'h1,
		PIO_ST_OFF  = 2'h3
	} pio_st_e;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Direct select bypasses the address map entirely
	function automatic pio_tgt_e pio_decode(input logic [`PIO_AW-1:0] a, input logic fsel);
		pio_tgt_e t;
		t = PIO_TGT_CSR;
		if (fsel)
			t = PIO_TGT_RXD;
		else if (a[6:4] == `PIO_RXD_TOP)
			t = PIO_TGT_RXD;
		else if ({a[6:1], 1'b0} == `PIO_RXS_ADDR)
			t = PIO_TGT_RXS;
		else if ({a[6:1], 1'b0} == `PIO_TXS_ADDR)
			t = PIO_TGT_TXS;
		return t;
	endfunction

	// Targets whose reads consume an entry
	function automatic logic pio_is_fifo(input pio_tgt_e t);
		return t != PIO_TGT_CSR;
	endfunction
endpackage

// ---- rtl/pio_bus_if.sv ----
`timescale 1ns/1ps
`include "pio_regs.svh"
interface pio_bus_if;
	import pio_pkg::*;

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	logic                select_n;        // Chip select, low active
	logic                read_strobe_n;   // Read strobe, low active
	logic                write_strobe_n;  // Write strobe, low active
	logic [`PIO_AW-1:0]  addr;            // Halfword address A[7:1]
	logic                fifo_sel;        // Direct receive FIFO select
	logic [`PIO_DW-1:0]  host_d;          // Host data out
	logic                host_d_oe;       // Host drives whole bus
	logic [`PIO_DW-1:0]  dev_d;           // Device data out
	logic                dev_d_oe_lo;     // Device drives D[15:0]
	logic                dev_d_oe_hi;     // Device drives D[31:16]
	logic                dev_wr_ready;    // Device has room for a write
	logic [`PIO_DW-1:0]  data_bus;        // Resolved bus level

	// Undriven halves read as zero; no tri-state inside the design
	assign data_bus[31:16] = dev_d_oe_hi ? dev_d[31:16] : (host_d_oe ? host_d[31:16] : 16'h0);
	assign data_bus[15:0]  = dev_d_oe_lo ? dev_d[15:0] : (host_d_oe ? host_d[15:0] : 16'h0);

	modport dev (
		input  select_n, read_strobe_n, write_strobe_n, addr, fifo_sel, data_bus,
		output dev_d, dev_d_oe_lo, dev_d_oe_hi, dev_wr_ready
	);
	modport host (
		input  data_bus, dev_wr_ready,
		output select_n, read_strobe_n, write_strobe_n, addr, fifo_sel, host_d, host_d_oe
	);
endinterface

// ---- rtl/pio_dev_port.sv ----
`timescale 1ns/1ps
`include "pio_regs.svh"
// What this block does
// [RQ1] Read cycle while select and read low
// [RQ2] Write cycle while select and write low
// [RQ3] Snapshot counters at read cycle start
// [RQ4] Reads reach registers, data and status FIFOs
// [RQ5] Sixteen-bit reads leave upper half undriven
// [RQ6] Sixteen-bit writes discard the upper half
// [RQ7] All writes are plain single cycles
// [RQ8] Host idles strobes 13 ns between cycles
// [RQ9] Host holds 32 ns, spaces starts 45 ns
// [RQ10] Addressed burst up to 8 or 16 reads
// [RQ11] Burst address 45 ns, data within 40 ns
// [RQ12] Host idles 13 ns between bursts
// [RQ13] Direct select reads always the data FIFO
// [RQ14] Direct reads use A[2:1], ignore A[7:3]
// [RQ15] Direct bursts unlimited, each read pops
// [RQ16] After direct burst, strobe high 13 ns
// [RQ17] Direct select timed like address lines
// [RQ18] Host waits after writes before reads
// [RQ19] Host waits 135 ns before info read
// [RQ20] Write data taken at cycle trailing edge
// [RQ21] One FIFO pop per completed read
module pio_dev_port
	import pio_pkg::*;
#(
	parameter int DEPTH = 2                        // Write buffer entries
) (
	input  logic                clk,
	input  logic                rst,
	input  logic                bus16,             // Strap: 16-bit bus mode
	pio_bus_if.dev              bus,
	output logic                rd_req,            // Pulse: fetch read data now
	output pio_tgt_e            rd_tgt,            // Target of the fetch
	output logic [`PIO_AW-1:0]  rd_addr,           // Address of the fetch
	output logic [1:0]          rd_word,           // A[2:1] word select
	input  logic [`PIO_DW-1:0]  rd_data,           // Data for the fetch, same cycle
	output logic                rd_snap,           // Pulse: latch counter snapshot
	output logic                rd_pop,            // Pulse: consume FIFO entry
	output pio_tgt_e            rd_pop_tgt,        // FIFO being consumed
	output logic                wr_valid,          // Buffered write present
	input  logic                wr_ready,          // User takes the write
	output logic [`PIO_AW-1:0]  wr_addr,           // Buffered write address
	output logic [`PIO_DW-1:0]  wr_data,           // Buffered write data
	output logic                wr_overrun         // Sticky: write lost on full
);

	// ----------------------------------------
	// Local sizes
	// ----------------------------------------
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;   // Pointer width
	localparam int CW = $clog2(DEPTH + 1);                  // Fill count width
	localparam int EW = `PIO_AW + `PIO_DW;                  // Entry width

	// ----------------------------------------
	// Cycle detection
	// ----------------------------------------
	logic                rd_act;        // Read strobes jointly low
	logic                wr_act;        // Write strobes jointly low
	logic                rd_act_q;      // Read active last cycle
	logic                wr_act_q;      // Write active last cycle
	logic                rd_start;      // First cycle of a read
	logic                rd_step;       // Burst address change
	logic                rd_end;        // Read just ended
	logic                rd_new;        // A fresh read begins
	logic                wr_end;        // Write just ended
	pio_tgt_e            tgt_now;       // Decoded target of live address

	// Strobes come from the host logic on this clock, so no synchroniser.
	// Either order of the two edges gives the same joint level.
	assign rd_act = ~bus.select_n & ~bus.read_strobe_n;   // RQ1
	assign wr_act = ~bus.select_n & ~bus.write_strobe_n;  // RQ2

	// Direct select overrides the upper address decode
	assign tgt_now = pio_decode(bus.addr, bus.fifo_sel);  // RQ13 RQ4

	// Previous activity levels
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [`PIO_AW-1:0]  raddr_q;       // Address of read in progress
	logic                rfsel_q;       // Direct select of read in progress
	pio_tgt_e            rtgt_q;        // Target of read in progress
	logic [`PIO_DW-1:0]  dout_q;        // Data presented on the bus

	assign rd_start = rd_act & ~rd_act_q;                                 // RQ1
	// Any address move under held strobes is a new back-to-back read
	assign rd_step  = rd_act & rd_act_q & ((bus.addr != raddr_q) | (bus.fifo_sel != rfsel_q)); // RQ10 RQ15
	assign rd_end   = ~rd_act & rd_act_q;                                 // RQ1
	assign rd_new   = rd_start | rd_step;

	// Fetch request to the register and FIFO side
	assign rd_req  = rd_new;
	assign rd_tgt  = tgt_now;
	assign rd_addr = bus.addr;
	// Word select survives in direct mode; A[7:3] only reaches the target through rd_addr
	assign rd_word = bus.addr[1:0];                                       // RQ14

	// Counters freeze once per cycle, not per burst beat, so a burst
	// of counter reads sees one coherent picture.
	assign rd_snap = rd_start & (tgt_now == PIO_TGT_CSR);                 // RQ3

	// An entry is used up when its read is over: the strobes rise or the
	// address moves on. Popping at the start would corrupt a slow read.
	assign rd_pop     = (rd_step | rd_end) & pio_is_fifo(rtgt_q);         // RQ21 RQ15
	assign rd_pop_tgt = rtgt_q;

	// Capture target and data when each read begins
	always_ff @(posedge clk) begin
		if (rst) begin
			raddr_q <= '0;
			rfsel_q <= 1'b0;
			rtgt_q  <= PIO_TGT_CSR;
			dout_q  <= '0;
		end else if (rd_new) begin
			raddr_q <= bus.addr;
			rfsel_q <= bus.fifo_sel;
			rtgt_q  <= tgt_now;
			// Narrow mode keeps only the low half meaningful
			if (bus16)
				dout_q <= {16'h0, rd_data[15:0]};                           // RQ5
			else
				dout_q <= rd_data;
		end
	end

	// Data is valid one edge after the strobes or address settle, well
	// inside the 30 ns and 40 ns limits at this clock rate.
	assign bus.dev_d = dout_q;                                            // RQ11
	// Drivers drop in the same cycle the strobes rise, which avoids a
	// full clock of contention with a following write.
	assign bus.dev_d_oe_lo = rd_act & rd_act_q;                           // RQ1
	// Upper half stays off the bus in narrow mode
	assign bus.dev_d_oe_hi = rd_act & rd_act_q & ~bus16;                  // RQ5

	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	logic [`PIO_AW-1:0]  waddr_q;       // Address of write in progress
	logic [`PIO_DW-1:0]  wdata_q;       // Last data seen during the write

	// Track the bus every active cycle; the final sample is the one
	// held just before the trailing edge.
	always_ff @(posedge clk) begin
		if (rst) begin
			waddr_q <= '0;
			wdata_q <= '0;
		end else if (wr_act) begin
			waddr_q <= bus.addr;
			if (bus16)
				wdata_q <= {16'h0, bus.data_bus[15:0]};                     // RQ6
			else
				wdata_q <= bus.data_bus;
		end
	end

	// Every write, register or FIFO alike, is one entry
	assign wr_end = ~wr_act & wr_act_q;                                   // RQ20 RQ7 RQ2

	// ----------------------------------------
	// Write buffer
	// ----------------------------------------
	logic [EW-1:0]       buf_mem [DEPTH];   // Entries, address over data
	logic [PW-1:0]       wp_q;              // Write pointer
	logic [PW-1:0]       rp_q;              // Read pointer
	logic [CW-1:0]       cnt_q;             // Fill count
	logic                full;              // No room left
	logic                do_push;           // Entry stored this cycle
	logic                do_pop;            // Entry taken this cycle
	logic                overrun_q;         // Lost write seen

	// Pointer advance with wrap, for any depth
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign full    = (cnt_q == CW'(DEPTH));
	assign do_push = wr_end & ~full;
	assign do_pop  = wr_valid & wr_ready;

	// Storage; entries are only written, never reset
	always_ff @(posedge clk) begin
		if (do_push)
			buf_mem[wp_q] <= {waddr_q, wdata_q};
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push)
				wp_q <= ptr_inc(wp_q);
			if (do_pop)
				rp_q <= ptr_inc(rp_q);
			if (do_push & ~do_pop)
				cnt_q <= cnt_q + CW'(1);
			else if (do_pop & ~do_push)
				cnt_q <= cnt_q - CW'(1);
		end
	end

	// The bus itself cannot stall, so a host ignoring the ready line
	// loses the word; this flag makes that visible until reset.
	always_ff @(posedge clk) begin
		if (rst)
			overrun_q <= 1'b0;
		else if (wr_end & full)
			overrun_q <= 1'b1;
	end

	// Drain side
	assign wr_valid   = (cnt_q != '0);
	assign wr_addr    = buf_mem[rp_q][EW-1 -: `PIO_AW];
	assign wr_data    = buf_mem[rp_q][`PIO_DW-1:0];
	assign wr_overrun = overrun_q;

	// Back-pressure reaches the host through the bus
	assign bus.dev_wr_ready = ~full;

endmodule // pio_dev_port

// ---- rtl/pio_host_port.sv ----
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_host_port
	import pio_pkg::*;
#(
	parameter int BEAT_W = 8                       // Burst length counter width
) (
	input  logic                clk,
	input  logic                rst,
	input  logic                bus16,             // Strap: 16-bit bus mode
	pio_bus_if.host             bus,
	input  logic                cmd_valid,         // Command offered
	output logic                cmd_ready,         // Command taken
	input  logic                cmd_write,         // 1 write, 0 read
	input  logic [`PIO_AW-1:0]  cmd_addr,          // Start halfword address
	input  logic                cmd_fifo_sel,      // Direct receive FIFO read
	input  logic [BEAT_W-1:0]   cmd_beats,         // Read beats, 0 counts as 1
	input  logic [`PIO_DW-1:0]  cmd_wdata,         // Write data
	output logic                rsp_valid,         // Pulse: read beat data
	output logic [`PIO_DW-1:0]  rsp_data,          // Read beat data
	output logic                rsp_last           // Beat is the last of its command
);

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam logic [4:0] WR_HOLD = 5'(`PIO_TCSL_CYC);        // Write low time
	localparam logic [4:0] RD_HOLD = 5'(`PIO_RD_HOLD_CYC);     // Read beat time
	localparam logic [4:0] OFF_CYC = 5'(`PIO_TCSH_CYC);        // High time
	localparam logic [4:0] RAW_CYC = 5'(`PIO_TRAW_CYC);        // Write to read
	localparam logic [4:0] RAR_CYC = 5'(`PIO_TRAR_CYC);        // FIFO to info read

	// ----------------------------------------
	// State
	// ----------------------------------------
	pio_st_e             st_q;          // Cycle state
	logic [4:0]          cnt_q;         // Cycles in current phase
	logic [BEAT_W-1:0]   beats_q;       // Beats left including current
	logic                wr_q;          // Current command is a write
	logic [`PIO_AW-1:0]  addr_q;        // Address on the bus
	logic                fsel_q;        // Direct select on the bus
	logic [`PIO_DW-1:0]  wdata_q;       // Write data on the bus
	logic [4:0]          raw_q;         // Wait left after a write
	logic [4:0]          rar_q;         // Wait left after a receive FIFO read
	logic                ok;            // Command may start now
	logic                go;            // Command starts
	logic                beat_end;      // Last cycle of a beat
	logic [BEAT_W-1:0]   lim;           // Addressed burst limit
	logic [BEAT_W-1:0]   beats_in;      // Beats of the offered read

	// Writes need room at the device; reads wait out settle times
	always_comb begin
		if (cmd_write)
			ok = bus.dev_wr_ready;
		else
			ok = (raw_q == 5'h0) &&                                         // RQ18
			     ((cmd_addr != `PIO_RXINFO_ADDR) || cmd_fifo_sel || (rar_q == 5'h0)); // RQ19
	end

	assign go        = (st_q == PIO_ST_IDLE) & cmd_valid & ok;
	assign cmd_ready = (st_q == PIO_ST_IDLE) & ok;
	assign beat_end  = (st_q == PIO_ST_ACT) & (cnt_q == ((wr_q ? WR_HOLD : RD_HOLD) - 5'h1)); // RQ9 RQ11

	// Addressed bursts are clipped; direct bursts are not
	assign lim      = bus16 ? BEAT_W'(`PIO_BURST16_MAX) : BEAT_W'(`PIO_BURST32_MAX);
	always_comb begin
		beats_in = (cmd_beats == '0) ? BEAT_W'(1) : cmd_beats;
		if (!cmd_fifo_sel && (beats_in > lim))
			beats_in = lim;                                               // RQ10 RQ15
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Strobes stay low across a burst; each beat holds one address
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q  <= PIO_ST_IDLE;
			cnt_q <= 5'h0;
		end else begin
			unique case (st_q)
				PIO_ST_IDLE: begin
					cnt_q <= 5'h0;
					if (go)
						st_q <= PIO_ST_ACT;
				end
				PIO_ST_ACT: begin
					if (beat_end) begin
						cnt_q <= 5'h0;
						if (wr_q || (beats_q == BEAT_W'(1)))
							st_q <= PIO_ST_OFF;
					end else begin
						cnt_q <= cnt_q + 5'h1;
					end
				end
				PIO_ST_OFF: begin
					// High time also pads the cycle past 45 ns
					if (cnt_q == (OFF_CYC - 5'h1))
						st_q <= PIO_ST_IDLE;                              // RQ8 RQ12 RQ16
					else
						cnt_q <= cnt_q + 5'h1;
				end
				default: begin
					st_q  <= PIO_ST_IDLE;
					cnt_q <= 5'h0;
				end
			endcase
		end
	end

	// Command fields; address and direct select move together
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q    <= 1'b0;
			addr_q  <= '0;
			fsel_q  <= 1'b0;
			wdata_q <= '0;
			beats_q <= '0;
		end else if (go) begin
			wr_q    <= cmd_write;
			addr_q  <= cmd_addr;
			fsel_q  <= cmd_fifo_sel;                                      // RQ17
			wdata_q <= cmd_wdata;
			beats_q <= cmd_write ? BEAT_W'(1) : beats_in;                 // RQ7
		end else if (beat_end && !wr_q && (beats_q != BEAT_W'(1))) begin
			// Next dword or word of the burst
			addr_q  <= addr_q + (bus16 ? 7'h1 : 7'h2);                    // RQ10 RQ11
			beats_q <= beats_q - BEAT_W'(1);
		end
	end

	// ----------------------------------------
	// Response
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
			rsp_last  <= 1'b0;
		end else begin
			rsp_valid <= beat_end & ~wr_q;
			if (beat_end && !wr_q) begin
				rsp_data <= bus16 ? {16'h0, bus.data_bus[15:0]} : bus.data_bus;
				rsp_last <= (beats_q == BEAT_W'(1));
			end
		end
	end

	// ----------------------------------------
	// Settle timers
	// ----------------------------------------
	// Worst case wait after any write, since the target of the next
	// read is not known here in general
	always_ff @(posedge clk) begin
		if (rst) begin
			raw_q <= 5'h0;
			rar_q <= 5'h0;
		end else begin
			if (beat_end && wr_q)
				raw_q <= RAW_CYC;                                         // RQ18
			else if (raw_q != 5'h0)
				raw_q <= raw_q - 5'h1;
			if (beat_end && !wr_q && (pio_decode(addr_q, fsel_q) inside {PIO_TGT_RXD, PIO_TGT_RXS}))
				rar_q <= RAR_CYC;                                         // RQ19
			else if (rar_q != 5'h0)
				rar_q <= rar_q - 5'h1;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	assign bus.select_n       = ~(st_q == PIO_ST_ACT);
	assign bus.read_strobe_n  = ~((st_q == PIO_ST_ACT) & ~wr_q);
	assign bus.write_strobe_n = ~((st_q == PIO_ST_ACT) & wr_q);
	assign bus.addr           = addr_q;
	assign bus.fifo_sel       = fsel_q;
	assign bus.host_d         = wdata_q;
	assign bus.host_d_oe      = (st_q == PIO_ST_ACT) & wr_q;

endmodule // pio_host_port

// ---- verif/pio_bus_properties.sv ----
`timescale 1ns/1ps
`include "pio_regs.svh"
// Pin rules between the two ends
module pio_bus_properties (
	input logic			clk,
	input logic			rst,
	input logic			bus16,
	input logic			select_n,
	input logic			read_strobe_n,
	input logic			write_strobe_n,
	input logic [`PIO_AW-1:0]	addr,
	input logic [`PIO_DW-1:0]	dev_d,
	input logic			dev_d_oe_lo,
	input logic			dev_d_oe_hi,
	input logic			dev_wr_ready
);
	// ----
	// Cycle decode
	// ----
	logic	rd_act;	// Read cycle live
	logic	wr_act;	// Write cycle live
	// Either strobe order works, so only the joint level counts
	assign rd_act = !select_n && !read_strobe_n;
	assign wr_act = !select_n && !write_strobe_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// Assertions
	// ----
	a_oe_needs_read: assert property (dev_d_oe_lo |-> rd_act)
		else $error("device drives bus outside a read");
	a_oe_after_start: assert property ($rose(rd_act) ##1 rd_act |-> dev_d_oe_lo)
		else $error("device silent in a read");
	a_upper_quiet: assert property (bus16 |-> !dev_d_oe_hi)
		else $error("upper half driven in narrow mode");
	a_upper_driven: assert property (!bus16 && dev_d_oe_lo |-> dev_d_oe_hi)
		else $error("upper half idle in wide mode");
	a_read_hold: assert property ($rose(rd_act) |-> rd_act [*2])
		else $error("read too short");
	a_write_hold: assert property ($rose(wr_act) |-> wr_act [*2])
		else $error("write too short");
	a_addr_hold: assert property (rd_act && $past(rd_act) && $changed(addr) |=> $stable(addr))
		else $error("burst address held one cycle");
	// Data settles one edge after the address and then must not move
	a_data_steady: assert property (rd_act && $past(rd_act) && $past(rd_act, 2) && $stable(addr)
		&& ($past(addr) == $past(addr, 2)) |-> $stable(dev_d))
		else $error("read data moved under steady address");
	a_write_room: assert property ($rose(wr_act) |-> $past(dev_wr_ready))
		else $error("write started into full buffer");
	a_off_time: assert property (($fell(rd_act) || $fell(wr_act)) |=> !rd_act && !wr_act)
		else $error("strobes not held high between cycles");
	c_step: cover property (rd_act && $past(rd_act) && $changed(addr));
	c_write: cover property ($rose(wr_act));
	c_narrow: cover property (bus16 && dev_d_oe_lo);
endmodule // pio_bus_properties

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "pio_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk = 0, rst = 1, bus16 = 0, stall = 0, wr_ready = 0;
	logic cmd_valid = 0, cmd_write = 0, cmd_fsel = 0, cmd_ready, rsp_valid, rsp_last;
	logic [6:0] cmd_addr = 0, rd_addr, wr_addr;
	logic [7:0] cmd_beats = 0;
	logic [31:0] cmd_wdata = 0, rsp_data, rd_data, wr_data, r, m;
	logic [1:0] rd_word;
	logic rd_snap, rd_pop, wr_valid, wr_overrun;
	pio_pkg::pio_tgt_e rd_tgt;
	logic [32:0] e;
	logic [38:0] w;
	logic [32:0] rq[$];	// Expected beats
	logic [31:0] mq[$];	// Bits that count
	logic [38:0] wq[$];	// Expected writes
	int errors = 0, checked = 0, pops = 0, snaps = 0, xpops = 0, xsnaps = 0, cyc = 0;
	always #12.5 clk = ~clk;
	// ----
	// Ends and checker
	// ----
	pio_bus_if pio_bus_if_inst ();
	// Fetch data encodes target and address, so a wrong decode shows
	assign rd_data = {16'h5a3c, rd_tgt, rd_word, 5'h0, rd_addr};
	pio_dev_port #(.DEPTH(2)) pio_dev_port_inst (.clk(clk), .rst(rst), .bus16(bus16), .bus(pio_bus_if_inst),
		.rd_req(), .rd_tgt(rd_tgt), .rd_addr(rd_addr), .rd_word(rd_word), .rd_data(rd_data), .rd_snap(rd_snap),
		.rd_pop(rd_pop), .rd_pop_tgt(), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_overrun(wr_overrun));
	pio_host_port pio_host_port_inst (.clk(clk), .rst(rst), .bus16(bus16), .bus(pio_bus_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_fifo_sel(cmd_fsel), .cmd_beats(cmd_beats), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_last(rsp_last));
	pio_bus_properties pio_bus_properties_inst (.clk(clk), .rst(rst), .bus16(bus16),
		.select_n(pio_bus_if_inst.select_n), .read_strobe_n(pio_bus_if_inst.read_strobe_n),
		.write_strobe_n(pio_bus_if_inst.write_strobe_n), .addr(pio_bus_if_inst.addr),
		.dev_d(pio_bus_if_inst.dev_d), .dev_d_oe_lo(pio_bus_if_inst.dev_d_oe_lo),
		.dev_d_oe_hi(pio_bus_if_inst.dev_d_oe_hi), .dev_wr_ready(pio_bus_if_inst.dev_wr_ready));
	// ----
	// Expectations
	// ----
	function automatic logic [1:0] tgt_of(logic [6:0] a, logic f);
		if (f || a[6:4] == 3'h0) return 2'h1;
		if (a[6:1] == 6'h10) return 2'h3;
		if (a[6:1] == 6'h12) return 2'h2;
		return 2'h0;
	endfunction
	// Narrow mode: upper half undriven reads as zero
	function automatic logic [31:0] cut(logic [31:0] d);
		return bus16 ? {16'h0, d[15:0]} : d;
	endfunction
	// ----
	// Drivers
	// ----
	task automatic issue(logic wrt, logic [6:0] a, logic f, logic [7:0] n, logic [31:0] d);
		int t;
		@(posedge clk);
		cmd_valid <= 1;
		cmd_write <= wrt;
		cmd_addr <= a;
		cmd_fsel <= f;
		cmd_beats <= n;
		cmd_wdata <= d;
		t = 0;
		// Ready is settled by the falling edge; acceptance is the next rise
		do begin @(negedge clk); t++; end while (cmd_ready !== 1'b1 && t < 400);
		`CHK("cmd_ready", 1'b1, cmd_ready)
		@(posedge clk);
		cmd_valid <= 0;
	endtask
	task automatic rd(logic [6:0] a, logic f, logic [7:0] n);
		int k;
		logic [6:0] x;
		k = (n == 0) ? 1 : n;
		// Addressed bursts stop at eight wide or sixteen narrow beats
		if (!f && k > (bus16 ? 16 : 8)) k = bus16 ? 16 : 8;
		for (int i = 0; i < k; i++) begin
			x = a + 7'(bus16 ? i : 2 * i);
			rq.push_back({i == k - 1, cut({16'h5a3c, tgt_of(x, f), x[1:0], 5'h0, x})});
			mq.push_back(f ? 32'hffff_ff80 : 32'hffff_ffff);
			if (tgt_of(x, f) != 2'h0) xpops++;
		end
		if (tgt_of(a, f) == 2'h0) xsnaps++;
		issue(0, a, f, n, 0);
	endtask
	task automatic wr(logic [6:0] a, logic [31:0] d);
		wq.push_back({a, cut(d)});
		issue(1, a, 0, 1, d);
	endtask
	// Receiver stalls at random, or fully while the buffer is filled
	always @(posedge clk) wr_ready <= !stall && ($urandom % 3 != 0);
	// ----
	// Monitor, on the falling edge where outputs are settled
	// ----
	always @(negedge clk) if (!rst) begin
		if (rd_pop === 1'b1) pops++;
		if (rd_snap === 1'b1) snaps++;
		if (rsp_valid === 1'b1) begin
			e = rq.pop_front();
			m = mq.pop_front();
			`CHK("rsp_data", e[31:0] & m, rsp_data & m)
			`CHK("rsp_last", e[32], rsp_last)
		end
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			w = wq.pop_front();
			`CHK("wr_word", w, {wr_addr, wr_data})
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin errors++; final_report(); end
	end
	task final_report;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		void'($urandom(32'h25de));
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int b = 0; b < 2; b++) begin
			@(posedge clk);
			bus16 <= b[0];
			@(posedge clk);
			rd(7'h00, 0, 1); rd(7'h20, 0, 1); rd(7'h24, 0, 1); rd(7'h3e, 0, 1); rd(7'h3a, 0, 0);
			rd(7'h7f, 1, 1); rd(7'h00, 0, 20); rd(7'h51, 1, 40);
			// Fill both entries with the receiver stalled
			stall <= 1;
			wr(7'h30, 32'hdead_beef);
			wr(7'h31, 32'h1234_5678);
			repeat (20) @(posedge clk);
			`CHK("full", 2'b10, {wr_valid, pio_bus_if_inst.dev_wr_ready})
			stall <= 0;
			repeat (14) begin
				r = $urandom;
				if (r[12]) wr(r[6:0], $urandom);
				else rd(r[6:0], r[7], {6'h0, r[9:8]});
			end
			repeat (60) @(posedge clk);
		end
		`CHK("pops", xpops, pops)
		`CHK("snaps", xsnaps, snaps)
		`CHK("overrun", 1'b0, wr_overrun)
		`CHK("pending", 0, rq.size() + wq.size())
		final_report();
	end
endmodule // tb
